/* src/dcs_dma_arb.sv */
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
module dcs_dma_arb #(
	parameter int NCH = 4
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  channel_request_pin_n_i,
	input  wire logic        terminate_count_pin_n_i,
	input  wire logic        refresh_req_i,
	input  wire logic        hold_req_i,
	output logic             refresh_gnt_o,
	output logic             hold_gnt_o,
	output logic             dma_own_o,
	output logic [1:0]       xfer_ch_o,
	output logic             xfer_start_o,
	output logic             irq_o
);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		// Bus slave answer
		logic                 ack;
		logic [31:0]          dat;
		logic                 irq;
		// Software-visible configuration and status
		logic                 rot;
		logic [1:0]           base;
		logic [7:0]           ist;
		logic [7:0]           ien;
		logic [3:0]           en;
		logic [3:0]           req;
		logic [3:0]           cs;
		logic [3:0]           chain;
		logic [3:0]           lvl;
		logic [3:0][15:0]     cnt;
		logic [3:0][15:0]     rld;
		logic [3:0][7:0]      blk;
		// Sequencer and the unit in flight
		dcs_pkg::dcs_state_t  st;
		logic [1:0]           ch;
		logic                 lock;
		logic [3:0]           ucnt;
		logic                 tch;
		logic                 start;
		// Grants, kept as flops so outputs need no decode
		logic                 gref;
		logic                 ghold;
		logic                 own;
		// Pin synchronisers; the third request flop finds edges
		logic [3:0]           s1;
		logic [3:0]           s2;
		logic [3:0]           s3;
		logic                 t1;
		logic                 t2;
	} dcs_state_rec_t;

	dcs_state_rec_t r_reg;
	dcs_state_rec_t r_next;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Highest eligible channel starting from the current top rank
	// Scans from lowest rank up so the top rank is written last
	function automatic logic [2:0] dcs_pick(input logic [3:0] elig,
		input logic [1:0] top);
		logic [2:0] res;
		logic [1:0] idx;
		res = 3'h0;
		idx = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			idx = top + 2'(k);
			if (elig[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction

	// Channel block decode, shared by the read and write paths
	function automatic logic dcs_is_ch(input logic [7:0] adr);
		return adr[7:5] == dcs_pkg::ADR_CH_BASE[7:5] && !adr[1];
	endfunction

	// Byte lane merge for wider fields
	// Only the count word honours lanes; other registers need lane 0
	function automatic logic [31:0] dcs_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic        wr;
		logic        rd;
		logic [3:0]  fall;
		logic [3:0]  swset;
		logic [3:0]  elig;
		logic [2:0]  pk;
		logic        arb;
		logic [1:0]  c;
		logic [1:0]  top;
		logic [2:0]  ci;
		logic [31:0] w;
		wr = 1'b0;
		rd = 1'b0;
		fall = 4'h0;
		swset = 4'h0;
		elig = 4'h0;
		pk = 3'h0;
		arb = 1'b0;
		c = r_reg.ch;
		top = 2'h0;
		ci = 3'h0;
		w = 32'h0;
		r_next = r_reg;
		r_next.ack = 1'b0;
		r_next.start = 1'b0;

		// Pins pass two flops; the third only serves edge detection
		// Idle level is high and the flops reset high, so no false edge
		r_next.s1 = channel_request_pin_n_i;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.t1 = terminate_count_pin_n_i;
		r_next.t2 = r_reg.t1;
		fall = r_reg.s3 & ~r_reg.s2; // R17

		// Bus slave: answer one clock after the request appears
		// A request still held while ack is high is not taken twice
		if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
			r_next.ack = 1'b1;
			wr = wb_we_i;
			rd = !wb_we_i;
		end
		ci = {1'b0, wb_adr_i[4:3]};
		// Read data is captured only on a taken read, then held
		if (rd) begin
			r_next.dat = 32'h0;
			case (wb_adr_i)
				dcs_pkg::ADR_CTRL: r_next.dat[0] = r_reg.rot;
				dcs_pkg::ADR_STATE: r_next.dat = {16'h0, r_reg.en,
					r_reg.req, 2'h0, r_reg.base, 1'b0,
					r_reg.own, r_reg.ch};
				dcs_pkg::ADR_IRQ_STAT: r_next.dat[7:0] = r_reg.ist;
				dcs_pkg::ADR_IRQ_EN: r_next.dat[7:0] = r_reg.ien;
				default: begin
					if (dcs_is_ch(wb_adr_i)) begin
						if (wb_adr_i[2]) begin
							r_next.dat = {8'h0, r_reg.blk[ci[1:0]],
								r_reg.cnt[ci[1:0]]};
						end else begin
							r_next.dat[5:0] = {r_reg.req[ci[1:0]],
								r_reg.lvl[ci[1:0]], r_reg.chain[ci[1:0]],
								r_reg.cs[ci[1:0]], 1'b0, r_reg.en[ci[1:0]]};
						end
					end
				end
			endcase
		end
		// Writes land at the taking edge, the same edge that raises ack
		if (wr) begin
			case (wb_adr_i)
				dcs_pkg::ADR_CTRL: if (wb_sel_i[0]) begin
					r_next.rot = wb_dat_i[dcs_pkg::BIT_PRIO_ROT]; // R10
				end
				dcs_pkg::ADR_IRQ_EN: if (wb_sel_i[0]) begin
					r_next.ien = wb_dat_i[7:0];
				end
				dcs_pkg::ADR_IRQ_CLR: if (wb_sel_i[0]) begin
					r_next.ist = r_reg.ist & ~wb_dat_i[7:0];
				end
				default: begin
					if (dcs_is_ch(wb_adr_i)) begin
						if (wb_adr_i[2]) begin
							w = dcs_merge({8'h0, r_reg.blk[ci[1:0]],
								r_reg.cnt[ci[1:0]]}, wb_dat_i, wb_sel_i);
							r_next.cnt[ci[1:0]] = w[15:0];
							r_next.rld[ci[1:0]] = w[15:0];
							r_next.blk[ci[1:0]] = w[23:16];
						end else if (wb_sel_i[0]) begin
							r_next.en[ci[1:0]] = wb_dat_i[dcs_pkg::BIT_EN];
							r_next.cs[ci[1:0]] = wb_dat_i[dcs_pkg::BIT_CSTEAL];
							r_next.chain[ci[1:0]] =
								wb_dat_i[dcs_pkg::BIT_CHAIN];
							r_next.lvl[ci[1:0]] = wb_dat_i[dcs_pkg::BIT_LEVEL];
							swset[ci[1:0]] = wb_dat_i[dcs_pkg::BIT_SWREQ];
							if (!wb_dat_i[dcs_pkg::BIT_EN]) begin
								r_next.req[ci[1:0]] = 1'b0;
							end
						end
					end
				end
			endcase
		end

		// Sequencer; a forced end waits for the running unit to finish
		// Idle and lent states re-arbitrate on every clock
		case (r_reg.st)
			dcs_pkg::ST_CPU: arb = 1'b1;
			dcs_pkg::ST_OTHER: arb = 1'b1;
			dcs_pkg::ST_XFER: begin
				r_next.ucnt = r_reg.ucnt - 4'h1;
				// Latch a terminate pulse so a short one is not lost
				if (!r_reg.t2) begin
					r_next.tch = 1'b1;
				end
				if (r_reg.ucnt == 4'h1) begin
					arb = 1'b1;
					if (r_reg.tch || !r_reg.t2 || !r_next.en[c]) begin
						// Forced end leaves the rotation alone
						r_next.en[c] = 1'b0; // R14
						r_next.req[c] = 1'b0;
						r_next.ist[c + 3'h4] = 1'b1;
						r_next.lock = 1'b0;
					end else if (r_reg.cnt[c] == 16'h1) begin
						// Another block follows: counter restarts from reload
						if (r_reg.chain[c] && r_reg.blk[c] != 8'h0) begin
							r_next.blk[c] = r_reg.blk[c] - 8'h1;
							r_next.cnt[c] = r_reg.rld[c];
						end else begin
							// Last unit of the last block: stop and report
							r_next.cnt[c] = 16'h0;
							r_next.en[c] = 1'b0; // R7
							r_next.req[c] = 1'b0;
							r_next.ist[c] = 1'b1;
							r_next.lock = 1'b0;
							if (r_reg.rot) begin
								r_next.base = c + 2'h1; // R13
							end
						end
					end else begin
						// Enable stays set between cycle steal units
						r_next.cnt[c] = r_reg.cnt[c] - 16'h1; // R6
					end
				end
			end
			default: arb = 1'b1;
		endcase

		// Arbitration point: other bus users first, then DMA, else CPU
		// Next-state flags let a finishing channel free its slot at once
		if (arb) begin
			r_next.gref = 1'b0;
			r_next.ghold = 1'b0;
			elig = r_next.req & r_next.en; // R15
			top = r_reg.rot ? r_next.base : 2'h0; // R11
			pk = dcs_pick(elig, top); // R18
			// Refresh then hold outrank every channel
			if (refresh_req_i) begin
				r_next.st = dcs_pkg::ST_OTHER; // R9
				r_next.gref = 1'b1; // R16
			end else if (hold_req_i) begin
				r_next.st = dcs_pkg::ST_OTHER; // R16
				r_next.ghold = 1'b1;
			end else if (r_next.lock && elig[r_reg.ch]
				&& !r_reg.cs[r_reg.ch]) begin
				// Burst keeps its channel until it finishes
				r_next.st = dcs_pkg::ST_XFER; // R12
				r_next.ucnt = dcs_pkg::UNIT_CYC;
				r_next.start = 1'b1;
				r_next.tch = 1'b0;
			end else if (pk[2]) begin
				r_next.st = dcs_pkg::ST_XFER; // R5
				r_next.ch = pk[1:0];
				r_next.ucnt = dcs_pkg::UNIT_CYC;
				r_next.start = 1'b1;
				r_next.tch = 1'b0;
				r_next.lock = !r_next.cs[pk[1:0]]; // R1
				if (r_next.cs[pk[1:0]]) begin
					r_next.req[pk[1:0]] = 1'b0; // R3
				end
			end else begin
				// Nobody asks, bus goes back to the CPU
				r_next.st = dcs_pkg::ST_CPU; // R4
				r_next.lock = 1'b0;
			end
		end

		// Request flags last so a new edge beats any clear
		// Level sense follows the pin only in burst; cycle steal uses edges
		for (int i = 0; i < NCH; i++) begin
			if (r_next.lvl[i] && !r_next.cs[i]) begin
				r_next.req[i] = ~r_reg.s2[i];
			end else if (fall[i] || swset[i]) begin
				r_next.req[i] = 1'b1; // R8
			end
		end
		r_next.irq = |(r_next.ist & r_next.ien);
		// Ownership flag registered so the output needs no decode
		r_next.own = r_next.st == dcs_pkg::ST_XFER;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Synchronous reset; fields not named here clear to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0; // R10
			// Active-low pins idle high, so their flops reset high
			r_reg.s1 <= ~dcs_pkg::RST_ZERO4;
			r_reg.s2 <= ~dcs_pkg::RST_ZERO4;
			r_reg.s3 <= ~dcs_pkg::RST_ZERO4;
			r_reg.t1 <= 1'b1;
			r_reg.t2 <= 1'b1;
			r_reg.st <= dcs_pkg::ST_CPU;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs straight from the record
	// ------------------------------------------------------------
	assign wb_dat_o      = r_reg.dat;
	assign wb_ack_o      = r_reg.ack;
	assign irq_o         = r_reg.irq;
	assign refresh_gnt_o = r_reg.gref;
	assign hold_gnt_o    = r_reg.ghold;
	assign dma_own_o     = r_reg.own;
	assign xfer_ch_o     = r_reg.ch;
	assign xfer_start_o  = r_reg.start;

endmodule
`default_nettype wire

/* src/dcs_pkg.sv */
// How it works
// R1 - Mode bit 2 set selects cycle steal for the channel, clear selects burst.
// R2 - Software must pair cycle steal with edge sensing, never level sensing.
// R3 - In cycle steal the request flag clears when the first transfer cycle starts.
// R4 - After one cycle steal unit, return the bus unless some channel still requests.
// R5 - Cycle steal re-arbitrates at the end of every transfer cycle.
// R6 - Cycle steal clears the flag per unit but keeps enable; next request resumes.
// R7 - Counter zero (single) or counter and block zero (chain) clear enable, end all.
// R8 - Requester drops its pin low before cycle end; flag sets again, next unit runs.
// R9 - Refresh or other higher bus users take the bus before any DMA channel.
// R10 - Control bit 0 picks fixed (0) or rotating (1) priority; resets to fixed.
// R11 - Fixed order is channel 0,1,2,3; rotating starts in that same order.
// R12 - Burst evaluates priority only at first acceptance; cycle steal every cycle.
// R13 - Rotating: a normally finished channel becomes lowest, the others move up.
// R14 - Rotating order stays unchanged when a transfer is forced to end.
// R15 - A request is accepted only while its flag and enable bit are both one.
// R16 - Bus priority: refresh, then external hold, then DMA, then CPU.
// R17 - Edge sensing (bit 4 zero, reset default) sets the flag on a falling pin edge.
// R18 - Several pending channels: grant only the highest in the current order.
`default_nettype none
package dcs_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_STATE    = 8'h04;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADR_IRQ_EN   = 8'h0C;
	localparam logic [7:0] ADR_IRQ_CLR  = 8'h10;
	localparam logic [7:0] ADR_CH_BASE  = 8'h20; // Channel i config at +8*i
	localparam logic [7:0] ADR_CH_CNT   = 8'h04; // Count word beside config

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_PRIO_ROT = 0;
	localparam int BIT_EN       = 0;
	localparam int BIT_SWREQ    = 1;
	localparam int BIT_CSTEAL   = 2;
	localparam int BIT_CHAIN    = 3;
	localparam int BIT_LEVEL    = 4;
	localparam int BIT_REQ      = 5;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [3:0] RST_ZERO4 = 4'h0;
	localparam logic [3:0] UNIT_CYC  = 4'h4; // Clocks per transfer unit

	typedef enum logic [1:0] {
		ST_CPU,
		ST_OTHER,
		ST_XFER
	} dcs_state_t;

endpackage
`default_nettype wire

/* verification/dcs_req_model.sv */
`default_nettype none
module dcs_req_model (
	input  wire logic       clk_i,
	input  wire logic [5:0] pulse_i,
	input  wire logic       refresh_gnt_i,
	input  wire logic       hold_gnt_i,
	output logic [3:0]      pin_n_o,
	output logic            refresh_req_o,
	output logic            hold_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] fire_d = 4'h0;
	logic       rf_q = 1'b0;
	logic       hd_q = 1'b0;
	// Two-cycle low pulse gives exactly one falling edge; line idles high
	assign pin_n_o = ~(pulse_i[3:0] | fire_d);
	assign refresh_req_o = rf_q;
	assign hold_req_o = hd_q;
	// Bus users keep asking until granted, then let go
	always @(posedge clk_i) begin
		fire_d <= pulse_i[3:0];
		rf_q <= refresh_gnt_i ? 1'b0 : (rf_q | pulse_i[4]);
		hd_q <= hold_gnt_i ? 1'b0 : (hd_q | pulse_i[5]);
	end
endmodule
`default_nettype wire

/* verification/dcs_sva.sv */
`default_nettype none
module dcs_sva #(
	parameter int NCH = 4
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       refresh_gnt_o,
	input wire logic       hold_gnt_o,
	input wire logic       dma_own_o,
	input wire logic [1:0] xfer_ch_o,
	input wire logic       xfer_start_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A unit is one start pulse and four owned cycles
	sequence gap_s;
		xfer_start_o ##1 !xfer_start_o [*3];
	endsequence
	sequence own4_s;
		dma_own_o [*4];
	endsequence
	unit_own_a: assert property (xfer_start_o |-> own4_s)
		else $error("unit shorter than four cycles");
	unit_gap_a: assert property (xfer_start_o |-> gap_s)
		else $error("unit restarted early");
	unit_ch_a: assert property (xfer_start_o |=> $stable(xfer_ch_o) [*3])
		else $error("channel changed inside unit");
	own_start_a: assert property ($rose(dma_own_o) |-> xfer_start_o)
		else $error("bus taken without unit start");
	own_end_a: assert property ($fell(dma_own_o) |-> $past(xfer_start_o, 4))
		else $error("bus released off a unit end");
	ch_range_a: assert property (xfer_start_o |-> int'(xfer_ch_o) < NCH)
		else $error("channel out of range");
	rfsh_excl_a: assert property (refresh_gnt_o |-> !dma_own_o && !hold_gnt_o)
		else $error("refresh shares the bus");
	hold_excl_a: assert property (hold_gnt_o |-> !dma_own_o)
		else $error("hold shares the bus with dma");
	ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
endmodule
bind dcs_dma_arb dcs_sva #(.NCH(NCH)) dcs_sva_inst (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .refresh_gnt_o(refresh_gnt_o),
	.hold_gnt_o(hold_gnt_o), .dma_own_o(dma_own_o), .xfer_ch_o(xfer_ch_o),
	.xfer_start_o(xfer_start_o));
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req = 1'b0;
	logic        we = 1'b0;
	logic        tc_n = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, rd;
	logic [5:0]  pls = 6'h00;
	logic [3:0]  pin_n;
	logic [1:0]  ch;
	logic [15:0] lg = 16'h0;
	logic        ack, rreq, hreq, rgnt, hgnt, own, st, irq;
	logic [31:0] cnt [4] = '{32'h2, 32'h3, 32'h1, 32'h2};
	logic [31:0] cfg [4] = '{32'h1, 32'h5, 32'h4, 32'h5};
	int          miscompares = 0;
	int          compares = 0;
	int          ticks = 0;
	always #50 clk_i = ~clk_i;
	dcs_dma_arb #(.NCH(4)) dcs_dma_arb_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .channel_request_pin_n_i(pin_n),
		.terminate_count_pin_n_i(tc_n), .refresh_req_i(rreq),
		.hold_req_i(hreq), .refresh_gnt_o(rgnt), .hold_gnt_o(hgnt),
		.dma_own_o(own), .xfer_ch_o(ch), .xfer_start_o(st), .irq_o(irq));
	dcs_req_model dcs_req_model_inst (.clk_i(clk_i), .pulse_i(pls),
		.refresh_gnt_i(rgnt), .hold_gnt_i(hgnt), .pin_n_o(pin_n),
		.refresh_req_o(rreq), .hold_req_o(hreq));
	task automatic conclude;
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Bus owner log, one hex digit per grant, newest on the right
	always @(posedge clk_i) begin
		if (st === 1'b1) lg <= {lg[11:0], 2'b00, ch};
		if ($rose(rgnt)) lg <= {lg[11:0], 4'h4};
		if ($rose(hgnt)) lg <= {lg[11:0], 4'h5};
		ticks++;
		if (ticks == 20000) begin
			miscompares++;
			conclude();
		end
	end
	// Request held whole until ack is sampled, then released
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = rd;
		req <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask
	// Pulse bits: [3:0] pin fire, [4] refresh, [5] hold
	task automatic fr(input logic [5:0] m);
		@(posedge clk_i);
		lg <= 16'h0;
		pls <= m;
		@(posedge clk_i);
		pls <= 6'h00;
	endtask
	// Idle long enough to cover the pin synchroniser and a full unit
	task automatic quiet;
		int n;
		n = 0;
		while (n < 12) begin
			@(posedge clk_i);
			n = (own === 1'b0) ? n + 1 : 0;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h00, 32'h0);
		rc(8'h04, 32'h0);
		rc(8'hFC, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h24 + 8'(8 * i), cnt[i]);
			bus(1'b1, 8'h20 + 8'(8 * i), cfg[i]);
		end
		fr(6'h07);
		quiet;
		`CHK(lg, 16'h0001)
		rc(8'h28, 32'h5);
		rc(8'h30, 32'h24);
		// Second falling edge lands inside the running unit
		fr(6'h02);
		@(posedge clk_i);
		fr(6'h02);
		quiet;
		`CHK(lg, 16'h0011)
		rc(8'h28, 32'h4);
		rc(8'h08, 32'h3);
		`CHK(irq, 1'b0)
		bus(1'b1, 8'h0C, 32'h2);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b1)
		bus(1'b1, 8'h10, 32'h2);
		repeat (2) @(posedge clk_i);
		`CHK(irq, 1'b0)
		rc(8'h10, 32'h0);
		fr(6'h38);
		quiet;
		`CHK(lg, 16'h0453)
		bus(1'b1, 8'h24, 32'h1);
		bus(1'b1, 8'h20, 32'h5);
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h30, 32'h5);
		quiet;
		`CHK(lg[3:0], 4'h2)
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rdat[5:4], 2'h3)
		fr(6'h09);
		quiet;
		`CHK(lg, 16'h0030)
		bus(1'b1, 8'h2C, 32'h1);
		bus(1'b1, 8'h28, 32'h5);
		tc_n <= 1'b0;
		fr(6'h02);
		quiet;
		tc_n <= 1'b1;
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rdat[5:4], 2'h1)
		rc(8'h08, 32'h2D);
		conclude();
	end
endmodule
`default_nettype wire
